// ===== core/sched_params.svh
// Purpose: Timing and encoding constants for the tick slot scheduler
// Assumes: 20 MHz core clock
// Notes:   Included by the motion stepper and scheduler modules
`ifndef SCHED_PARAMS_SVH
`define SCHED_PARAMS_SVH
`define CLK_PERIOD_NS      50
`define TICK_TIME_NS       250000
`define TICK_CYCLES        (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define SERVO_HALF_MS      1'h0
`define SERVO_FULL_MS      1'h1
`define TASK_CMDLINE       2'h0
`define TASK_LOW1          2'h1
`define TASK_HIGH2         2'h2
`define TASK_HIGH3         2'h3
`define MOTION_STEPS       7
`endif

// ===== core/sched_pkg.sv
// Purpose: Types shared by the scheduler modules
// Assumes: Four tasks, four routines per millisecond
// Notes:   Constants live in sched_params.svh
package sched_pkg;
  typedef enum logic [6:0] {
    ST_TRANSFER = 7'h01,
    ST_READ_IN  = 7'h02,
    ST_LOAD     = 7'h04,
    ST_PROFILE  = 7'h08,
    ST_POSITION = 7'h10,
    ST_SERVO    = 7'h20,
    ST_UPDATE   = 7'h40
  } motion_step_e;

  typedef struct packed {
    logic       valid;
    logic [1:0] task_id;
  } slot_grant_s;

  typedef struct packed {
    logic       latch_inputs;
    logic       analog_update;
    logic       digital_update;
    logic       capture_inputs;
  } io_strobe_s;
endpackage

// ===== core/motion_seq.sv
// Purpose: Motion sequence stepper across all axes
// Assumes: Started by a one-cycle start pulse; axes handled one per cycle
// Notes:   Steps three to six walk every axis before moving on
`include "sched_params.svh"
module motion_seq #(
  parameter int NUM_AXES = 4
) (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_ce,
  input  wire logic                      i_start,
  output logic                           o_busy,
  output sched_pkg::motion_step_e        o_step,
  output logic [$clog2(NUM_AXES+1)-1:0]  o_axis,
  output logic                           o_drive_comm
);
  import sched_pkg::*;
  localparam int AW = $clog2(NUM_AXES + 1);

  typedef struct packed {
    logic         busy;
    motion_step_e step;
    logic [AW-1:0] axis;
    logic         comm;
  } mseq_state_s;

  mseq_state_s st;
  mseq_state_s next_st;

  // Per-axis steps hold until the last axis is done
  function automatic logic per_axis(input motion_step_e s);
    per_axis = (s == ST_LOAD) || (s == ST_PROFILE) || (s == ST_POSITION) || (s == ST_SERVO);
  endfunction

  // Step sequencing
  always_comb
  begin
    next_st = st;
    next_st.comm = 1'b0;
    if (!st.busy)
    begin
      if (i_start)
      begin
        next_st.busy = 1'b1;
        next_st.step = ST_TRANSFER;
        next_st.axis = '0;
      end
    end
    else if (per_axis(st.step) && (st.axis != AW'(NUM_AXES - 1)))
    begin
      next_st.axis = st.axis + AW'(1);
    end
    else
    begin
      next_st.axis = '0;
      unique case (st.step)
        ST_TRANSFER: next_st.step = ST_READ_IN;
        ST_READ_IN:  next_st.step = ST_LOAD;
        ST_LOAD:     next_st.step = ST_PROFILE;
        ST_PROFILE:  next_st.step = ST_POSITION;
        ST_POSITION: next_st.step = ST_SERVO;
        ST_SERVO:    next_st.step = ST_UPDATE;
        ST_UPDATE:   next_st.busy = 1'b0;
        default:     next_st.busy = 1'b0;
      endcase
    end
    // Drive exchange rides with axis 0 servo step
    if (next_st.busy && next_st.step == ST_SERVO && next_st.axis == '0)
      next_st.comm = 1'b1;
  end

  // State register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      st <= '{busy: 1'b0, step: ST_TRANSFER, axis: '0, comm: 1'b0};
    else if (i_ce)
      st <= next_st;
  end

  assign o_busy       = st.busy;
  assign o_step       = st.step;
  assign o_axis       = st.axis;
  assign o_drive_comm = st.comm;

  // Checks
  comm_axis0_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st.comm |-> (st.step == ST_SERVO && st.axis == '0))
    else $error("drive exchange outside axis 0 servo step");
  step_order_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.busy && st.step == ST_TRANSFER) |=> st.step == ST_READ_IN)
    else $error("motion step order broken");
  axis_walk_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.busy && st.step == ST_LOAD && st.axis != AW'(NUM_AXES-1))
      |=> (st.step == ST_LOAD && st.axis == $past(st.axis) + AW'(1)))
    else $error("axis walk skipped");
endmodule

// ===== core/servo_tick_task_slot_scheduler.sv
// Purpose: 250 us tick scheduler: routines, I/O refresh, task slots
// Assumes: 20 MHz core clock; task run flags come from program control
// Notes:   No I/O reaction besides registration; programs act on images
`include "sched_params.svh"
module servo_tick_task_slot_scheduler #(
  parameter int IN_W      = 8,
  parameter int OUT_W     = 8,
  parameter int NUM_AXES  = 4,
  parameter int TICK_CYC  = `TICK_CYCLES
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_ce,
  input  wire logic                   i_servo_period_sel,
  input  wire logic [IN_W-1:0]        i_dig_in,
  input  wire logic [OUT_W-1:0]       i_output_image_variable,
  input  wire logic                   i_run_req,
  input  wire logic                   i_run_explicit,
  input  wire logic [1:0]             i_run_task,
  input  wire logic                   i_stop_req,
  input  wire logic [1:0]             i_stop_task,
  input  wire logic                   i_halt_req,
  output logic                        o_tick,
  output logic [1:0]                  o_routine,
  output logic                        o_motion_start,
  output logic                        o_serial_run,
  output logic                        o_led_update,
  output logic                        o_comms_run,
  output sched_pkg::slot_grant_s      o_slot,
  output sched_pkg::io_strobe_s       o_io,
  output logic [IN_W-1:0]             o_input_variable,
  output logic [OUT_W-1:0]            o_dig_out,
  output logic                        o_analog_update,
  output logic [3:0]                  o_task_running,
  output logic                        o_run_reject,
  output logic                        o_motion_busy,
  output sched_pkg::motion_step_e     o_motion_step,
  output logic [$clog2(NUM_AXES+1)-1:0] o_motion_axis,
  output logic                        o_drive_comm
);
  import sched_pkg::*;
  localparam int TW = $clog2(TICK_CYC);

  typedef struct packed {
    logic [TW-1:0]    tick_cnt;
    logic             tick;
    logic [1:0]       routine;
    logic             period;
    logic [IN_W-1:0]  sync1;
    logic [IN_W-1:0]  sync2;
    logic [IN_W-1:0]  sync3;
    logic [IN_W-1:0]  captured;
    logic [IN_W-1:0]  in_var;
    logic [OUT_W-1:0] dig_out;
    logic [2:0]       io_phase;
    io_strobe_s       io;
    logic             analog;
    logic             motion_start;
    logic             serial;
    logic             led;
    logic             comms;
    slot_grant_s      slot;
    logic [3:0]       running;
    logic             rr_ptr;
    logic             reject;
  } sched_state_s;

  sched_state_s st;
  sched_state_s next_st;
  logic         ms_busy;
  logic         ms_comm;
  logic [3:0]   hi_run;
  logic [3:0]   lo_run;

  // Highest free task number, for run without explicit task
  function automatic logic [2:0] pick_free(input logic [3:0] run);
    pick_free = 3'h4;
    for (int t = 0; t < 4; t++)
      if (!run[t])
        pick_free = {1'b0, 2'(t)};
  endfunction

  // Pick one of two tasks, preferring the first when both run
  function automatic slot_grant_s pick2(input logic a_on, input logic [1:0] a,
                                        input logic b_on, input logic [1:0] b);
    pick2.valid   = a_on | b_on;
    pick2.task_id = a_on ? a : b;
  endfunction

  assign hi_run = {st.running[3], st.running[2], 2'h0};
  assign lo_run = {2'h0, st.running[1], st.running[0]};

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb
  begin
    logic [2:0] freet;
    freet   = pick_free(st.running);
    next_st = st;
    next_st.tick         = 1'b0;
    next_st.motion_start = 1'b0;
    next_st.serial       = 1'b0;
    next_st.led          = 1'b0;
    next_st.comms        = 1'b0;
    next_st.analog       = 1'b0;
    next_st.io           = '0;
    next_st.slot         = '0;
    next_st.reject       = 1'b0;

    // Pin inputs through three stages; value moves once the last two stages agree
    next_st.sync1 = i_dig_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // Fixed 250 us tick
    if (st.tick_cnt == TW'(TICK_CYC - 1))
    begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;
    end
    else
      next_st.tick_cnt = st.tick_cnt + TW'(1);

    // Routine dispatch on each tick
    if (st.tick)
    begin
      next_st.routine = st.routine + 2'h1;
      unique case (st.routine)
        2'h0:
        begin
          // Routine 1: motion then low slot; period latched per millisecond
          next_st.period       = i_servo_period_sel;
          next_st.motion_start = 1'b1;
          if (|lo_run)
          begin
            next_st.slot = pick2(st.rr_ptr ? lo_run[1] : lo_run[0], {1'b0, st.rr_ptr},
                                 st.rr_ptr ? lo_run[0] : lo_run[1], {1'b0, ~st.rr_ptr});
            next_st.rr_ptr = ~st.rr_ptr;
          end
          else
            next_st.slot = pick2(hi_run[3], `TASK_HIGH3, hi_run[2], `TASK_HIGH2);
        end
        2'h1:
        begin
          next_st.serial = 1'b1;
          if (|hi_run)
            next_st.slot = pick2(hi_run[3], `TASK_HIGH3, hi_run[2], `TASK_HIGH2);
          else
            next_st.slot = pick2(lo_run[0], `TASK_CMDLINE, lo_run[1], `TASK_LOW1);
        end
        2'h2:
        begin
          next_st.led          = 1'b1;
          next_st.motion_start = (st.period == `SERVO_HALF_MS);
          if (|hi_run)
            next_st.slot = pick2(hi_run[2], `TASK_HIGH2, hi_run[3], `TASK_HIGH3);
          else
            next_st.slot = pick2(lo_run[1], `TASK_LOW1, lo_run[0], `TASK_CMDLINE);
        end
        2'h3: next_st.comms = 1'b1;
      endcase
    end

    // I/O refresh sequence at each servo cycle start
    if (next_st.motion_start)
      next_st.io_phase = 3'h1;
    else if (st.io_phase != 3'h0)
      next_st.io_phase = (st.io_phase == 3'h4) ? 3'h0 : st.io_phase + 3'h1;
    unique case (st.io_phase)
      3'h1:
      begin
        next_st.io.latch_inputs = 1'b1;
        next_st.in_var = st.captured;
      end
      3'h2:
      begin
        next_st.io.analog_update = 1'b1;
        next_st.analog = 1'b1;
      end
      3'h3:
      begin
        next_st.io.digital_update = 1'b1;
        next_st.dig_out = i_output_image_variable;
      end
      3'h4:
      begin
        next_st.io.capture_inputs = 1'b1;
        if (st.sync2 == st.sync3)
          next_st.captured = st.sync3;
      end
      default: ;
    endcase

    // Program control: halt wins; else stop applies, then run, so run wins when both name one task
    if (i_halt_req)
      next_st.running = 4'h0;
    else
    begin
      if (i_stop_req)
        next_st.running[i_stop_task] = 1'b0;
      if (i_run_req)
      begin
        if (i_run_explicit)
          next_st.running[i_run_task] = 1'b1;
        else if (!freet[2])
          next_st.running[freet[1:0]] = 1'b1;
        else
          next_st.reject = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end

  // Motion sequence stepper
  motion_seq #(
    .NUM_AXES (NUM_AXES)
  ) motion_seq_i (
    .i_core_clk   (i_core_clk),
    .i_nrst       (i_nrst),
    .i_ce         (i_ce),
    .i_start      (st.motion_start),
    .o_busy       (ms_busy),
    .o_step       (o_motion_step),
    .o_axis       (o_motion_axis),
    .o_drive_comm (ms_comm)
  );

  // Outputs from flip-flops
  assign o_tick           = st.tick;
  assign o_routine        = st.routine;
  assign o_motion_start   = st.motion_start;
  assign o_serial_run     = st.serial;
  assign o_led_update     = st.led;
  assign o_comms_run      = st.comms;
  assign o_slot           = st.slot;
  assign o_io             = st.io;
  assign o_input_variable = st.in_var;
  assign o_dig_out        = st.dig_out;
  assign o_analog_update  = st.analog;
  assign o_task_running   = st.running;
  assign o_run_reject     = st.reject;
  assign o_motion_busy    = ms_busy;
  assign o_drive_comm     = ms_comm;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  tick_spacing_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.tick_cnt == TW'(TICK_CYC - 1)) |=> (st.tick && st.tick_cnt == '0))
    else $error("tick spacing broken");
  routine_step_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.tick) |=> st.routine == $past(st.routine) + 2'h1)
    else $error("routine counter did not advance");
  full_ms_motion_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.tick && st.routine == 2'h2 && st.period == `SERVO_FULL_MS) |=> !st.motion_start)
    else $error("motion ran in routine three at 1 ms period");
  high_slot_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.tick && st.routine == 2'h1 && (|hi_run) && !i_halt_req)
      |=> (st.slot.valid && st.slot.task_id[1]))
    else $error("high slot not given to high task");
  low_slot_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.tick && st.routine == 2'h0 && (|lo_run)) |=> !st.slot.task_id[1])
    else $error("low slot given to high task");
  halt_all_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && i_halt_req) |=> st.running == 4'h0)
    else $error("halt left a task running");
  io_order_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.io.latch_inputs) ##1 i_ce |-> st.io.analog_update)
    else $error("I/O refresh out of order");
  in_latency_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    (i_ce && st.io_phase == 3'h1) |=> st.in_var == $past(st.captured))
    else $error("input variable not previous snapshot");
  two_high_c: cover property (@(posedge i_core_clk) st.running[3] && st.running[2] && st.tick);
  half_ms_c:  cover property (@(posedge i_core_clk) st.period == `SERVO_HALF_MS && st.motion_start);
  reject_c:   cover property (@(posedge i_core_clk) st.reject);
endmodule

// ===== tb/servo_tick_task_slot_scheduler_test.sv
// Purpose: Self-checking bench for the tick slot scheduler
// Assumes: Tick shortened to 20 cycles; inputs driven 1 ns after rising edge
// Notes:   Slot table rows first, then reset and awkward cases by hand
module servo_tick_task_slot_scheduler_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sched_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int TICK  = 20;
  localparam int AXES  = 4;
  localparam int LIMIT = 30000;

  typedef struct packed {
    logic       sel;
    logic [3:0] run;
    logic [3:0] ok1;
    logic [3:0] ok2;
    logic [3:0] ok3;
    logic       alt;
  } row_s;

  logic                 i_core_clk              = 1'h0;
  logic                 i_nrst                  = 1'h0;
  logic                 i_ce                    = 1'h1;
  logic                 i_servo_period_sel      = 1'h1;
  logic [7:0]           i_dig_in                = 8'h00;
  logic [7:0]           i_output_image_variable = 8'h00;
  logic                 i_run_req               = 1'h0;
  logic                 i_run_explicit          = 1'h0;
  logic [1:0]           i_run_task              = 2'h0;
  logic                 i_stop_req              = 1'h0;
  logic [1:0]           i_stop_task             = 2'h0;
  logic                 i_halt_req              = 1'h0;
  logic                 o_tick, o_motion_start, o_serial_run, o_led_update, o_comms_run;
  logic [1:0]           o_routine;
  slot_grant_s          o_slot;
  io_strobe_s           o_io;
  logic [7:0]           o_input_variable, o_dig_out;
  logic [3:0]           o_task_running;
  logic                 o_analog_update, o_run_reject, o_motion_busy, o_drive_comm;
  logic [2:0]           axis;
  motion_step_e         o_servo_step_q;
  int                   n_fail          = 0;
  int                   samples_checked = 0;
  int                   cycles          = 0;

  // Slot table: period, running set, allowed tasks per slot, low turns
  row_s rows [6] = '{
    '{1'h1, 4'hb, 4'h3, 4'h8, 4'h8, 1'h1},
    '{1'h0, 4'hf, 4'h3, 4'h8, 4'h4, 1'h1},
    '{1'h1, 4'h8, 4'h8, 4'h8, 4'h8, 1'h0},
    '{1'h0, 4'h3, 4'h3, 4'h3, 4'h3, 1'h0},
    '{1'h1, 4'h4, 4'h4, 4'h4, 4'h4, 1'h0},
    '{1'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'h0}
  };

  servo_tick_task_slot_scheduler #(
    .IN_W(8), .OUT_W(8), .NUM_AXES(AXES), .TICK_CYC(TICK)
  ) servo_tick_task_slot_scheduler_i (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_servo_period_sel(i_servo_period_sel), .i_dig_in(i_dig_in),
    .i_output_image_variable(i_output_image_variable), .i_run_req(i_run_req),
    .i_run_explicit(i_run_explicit), .i_run_task(i_run_task), .i_stop_req(i_stop_req),
    .i_stop_task(i_stop_task), .i_halt_req(i_halt_req), .o_tick(o_tick),
    .o_routine(o_routine), .o_motion_start(o_motion_start), .o_serial_run(o_serial_run),
    .o_led_update(o_led_update), .o_comms_run(o_comms_run), .o_slot(o_slot), .o_io(o_io),
    .o_input_variable(o_input_variable), .o_dig_out(o_dig_out),
    .o_analog_update(o_analog_update), .o_task_running(o_task_running),
    .o_run_reject(o_run_reject), .o_motion_busy(o_motion_busy), .o_drive_comm(o_drive_comm),
    .o_motion_step(o_servo_step_q), .o_motion_axis(axis)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------
  always #25 i_core_clk = ~i_core_clk;

  // Hang guard
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      $display("CHECK FAILED run length expected below %0d seen %0d", LIMIT, cycles);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // Drivers and watchers
  // ----------------------------------------------------------------
  // Kind bits: halt, stop, run; reject is gathered over three cycles
  task automatic pulse(input logic [2:0] kind, input logic expl, input logic [1:0] id,
                       output logic rej);
    @(posedge i_core_clk);
    #1;
    {i_halt_req, i_stop_req, i_run_req} = kind;
    i_run_explicit = expl;
    i_run_task     = id;
    i_stop_task    = id;
    @(posedge i_core_clk);
    #1;
    {i_halt_req, i_stop_req, i_run_req} = 3'h0;
    rej = 1'h0;
    repeat (3)
    begin
      @(negedge i_core_clk);
      rej = rej | o_run_reject;
    end
  endtask

  // Which: 0 tick, 1 input latch, 2 motion start; stops at that negedge
  task automatic wait_for(input int which);
    int n;
    n = 0;
    do
    begin
      @(negedge i_core_clk);
      n++;
    end
    while (!(which == 0 ? o_tick === 1'h1 : which == 1 ? o_io.latch_inputs === 1'h1
             : o_motion_start === 1'h1) && n < 8 * TICK);
    if (n >= 8 * TICK)
    begin
      n_fail++;
      $display("CHECK FAILED wait %0d expected event seen none", which);
    end
  endtask

  // Events of one routine: motion, serial, leds, comms, slot valid
  task automatic watch(output logic [4:0] ev, output logic [1:0] st);
    wait_for(0);
    ev = 5'h00;
    st = 2'h0;
    repeat (4)
    begin
      @(negedge i_core_clk);
      ev = ev | {o_motion_start, o_serial_run, o_led_update, o_comms_run, o_slot.valid};
      if (o_slot.valid === 1'h1)
        st = o_slot.task_id;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    row_s                r;
    logic [4:0]          ev;
    logic [4:0]          exp;
    logic [1:0]          st;
    logic [1:0]          low [2];
    logic [3:0]          ok;
    logic                rej;
    logic [15:0]         seq;
    motion_step_e        ord [7];
    int                  j, run, bad, comm, n;
    ord = '{ST_TRANSFER, ST_READ_IN, ST_LOAD, ST_PROFILE, ST_POSITION, ST_SERVO, ST_UPDATE};
    repeat (5) @(posedge i_core_clk);
    #1 i_nrst = 1'h1;
    @(negedge i_core_clk);
    check16("running after reset", 16'h0000, {12'h000, o_task_running});
    // Slot table
    foreach (rows[k])
    begin
      r = rows[k];
      @(posedge i_core_clk);
      #1 i_servo_period_sel = r.sel;
      pulse(3'h4, 1'h0, 2'h0, rej);
      for (int t = 0; t < 4; t++)
        if (r.run[t])
          pulse(3'h1, 1'h1, t[1:0], rej);
      check16("running set", {12'h000, r.run}, {12'h000, o_task_running});
      n = 0;
      do
        watch(ev, st);
      while (ev[3] !== 1'h1 && n++ < 8);
      watch(ev, st);
      watch(ev, st);
      for (int ms = 0; ms < 2; ms++)
        for (int rt = 0; rt < 4; rt++)
        begin
          watch(ev, st);
          ok  = rt == 0 ? r.ok1 : rt == 1 ? r.ok2 : r.ok3;
          exp = rt == 0 ? {4'h8, |r.ok1} : rt == 1 ? {4'h4, |r.ok2}
              : rt == 2 ? {~r.sel, 3'h2, |r.ok3} : 5'h02;
          check16("routine events", {11'h000, exp}, {11'h000, ev});
          if (rt < 3 && ev[0] === 1'h1)
            check1("slot owner", 1'h1, ok[st]);
          if (rt == 0)
            low[ms] = st;
        end
      if (r.alt)
        check1("low turns", 1'h1, low[0] !== low[1]);
      $display("test slot row %0d finished", k);
    end
    // Program control: highest free, reject, stop, halt
    @(posedge i_core_clk);
    #1 i_servo_period_sel = 1'h1;
    pulse(3'h4, 1'h0, 2'h0, rej);
    for (int t = 0; t < 4; t++)
    begin
      pulse(3'h1, 1'h0, 2'h0, rej);
      check16("auto task", {12'h000, 4'hf << (3 - t)}, {12'h000, o_task_running});
      check1("no reject", 1'h0, rej);
    end
    pulse(3'h1, 1'h0, 2'h0, rej);
    check1("reject when full", 1'h1, rej);
    pulse(3'h2, 1'h0, 2'h2, rej);
    check16("stop one", 16'h000b, {12'h000, o_task_running});
    pulse(3'h1, 1'h0, 2'h0, rej);
    check16("refill freed", 16'h000f, {12'h000, o_task_running});
    pulse(3'h5, 1'h0, 2'h0, rej);
    check16("halt wins", 16'h0000, {12'h000, o_task_running});
    $display("test program control finished");
    // I/O refresh order and input latency
    @(posedge i_core_clk);
    #1 i_output_image_variable = 8'h3c;
    wait_for(1);
    seq = {12'h000, o_io};
    repeat (3)
    begin
      @(negedge i_core_clk);
      seq = {seq[11:0], o_io};
      if (o_io.analog_update === 1'h1)
        check1("analog pulse", 1'h1, o_analog_update);
    end
    check16("io order", 16'h8421, seq);
    repeat (3) @(posedge i_core_clk);
    #1 i_dig_in = 8'ha5;
    check16("digital out", 16'h003c, {8'h00, o_dig_out});
    wait_for(1);
    repeat (2) @(negedge i_core_clk);
    check16("input one late", 16'h0000, {8'h00, o_input_variable});
    wait_for(1);
    repeat (2) @(negedge i_core_clk);
    check16("input snapshot", 16'h00a5, {8'h00, o_input_variable});
    check16("no input reaction", 16'h003c, {8'h00, o_dig_out});
    $display("test io refresh finished");
    // Motion step order across axes
    wait_for(2);
    j = 0;
    run = 0;
    bad = 0;
    comm = 0;
    n = 0;
    @(negedge i_core_clk);
    while (o_motion_busy === 1'h1 && n++ < 200)
    begin
      if (o_servo_step_q !== ord[j])
      begin
        if (j >= 2 && j <= 5 && run != AXES)
          bad++;
        if (j < 6)
          j++;
        run = 0;
        if (o_servo_step_q !== ord[j])
          bad++;
      end
      if (j >= 2 && j <= 5 && axis !== run[2:0])
        bad++;
      if (o_drive_comm === 1'h1)
        comm = comm + ((o_servo_step_q === ST_SERVO && axis === 3'h0) ? 1 : 100);
      run++;
      @(negedge i_core_clk);
    end
    check16("motion order errors", 16'h0000, bad[15:0]);
    check16("last motion step", 16'h0006, j[15:0]);
    check16("drive exchanges", 16'h0001, comm[15:0]);
    $display("test motion sequence finished");
    // Clock enable low freezes the tick
    @(posedge i_core_clk);
    #1 i_ce = 1'h0;
    n = 0;
    repeat (3 * TICK)
    begin
      @(negedge i_core_clk);
      n = n + int'(o_tick === 1'h1);
    end
    check16("ticks while frozen", 16'h0000, n[15:0]);
    @(posedge i_core_clk);
    #1 i_ce = 1'h1;
    $display("test clock enable finished");
    // Reset in mid-run clears tasks and grants
    pulse(3'h1, 1'h1, 2'h3, rej);
    @(posedge i_core_clk);
    #1 i_nrst = 1'h0;
    repeat (5) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check16("reset outputs", 16'h0000, {o_task_running, o_slot, o_io, o_tick, o_routine, 1'h0});
    check16("reset data", 16'h0000, {o_input_variable, o_dig_out});
    @(posedge i_core_clk);
    #1 i_nrst = 1'h1;
    wait_for(0);
    $display("test mid reset finished");
    test_done();
  end
endmodule
